// ---- pkg/evpd_consts.vh ----
// Purpose: constants of the exception vector priority decoder
// Assumes: included by the decoder only
// Notes: offsets are byte offsets from the vector base
`ifndef EVPD_CONSTS_VH
`define EVPD_CONSTS_VH
// ----------------------------------------
// vector table
// ----------------------------------------
`define EVPD_RESET_VEC 24'h0ffffc
`define EVPD_BASE_RST 24'hfffe00
`define EVPD_OFS_PAGE1 24'h0001f8
`define EVPD_OFS_PAGE2 24'h0001f4
`define EVPD_OFS_SOFT 24'h0001f0
`define EVPD_OFS_KCALL 24'h0001ec
`define EVPD_OFS_MEXC 24'h0001e8
`define EVPD_OFS_RSV1 24'h0001e4
`define EVPD_OFS_RSV0 24'h0001e0
`define EVPD_OFS_SPUR 24'h0001dc
`define EVPD_OFS_XPIN 24'h0001d8
`define EVPD_OFS_EPIN 24'h0001d4
`define EVPD_OFS_MLO 24'h000010
`define EVPD_OFS_MHI 24'h0001d0
`define EVPD_TBL_ENTRIES 8'h80
`define EVPD_ENTRY_BITS 6'h20
`define EVPD_ADDR_BITS 5'h18
// ----------------------------------------
// channel indices (offset divided by four)
// ----------------------------------------
`define EVPD_CH_MLO 7'h04
`define EVPD_CH_MHI 7'h74
`define EVPD_CH_EPIN 7'h75
`define EVPD_CH_SPUR 7'h77
// ----------------------------------------
// priority levels
// ----------------------------------------
`define EVPD_LVL_RST 3'h1
`define EVPD_LVL_SPUR 3'h7
`define EVPD_LVL_OFF 3'h0
`define EVPD_NEST_MAX 3'h7
// ----------------------------------------
// apb register map
// ----------------------------------------
`define EVPD_REG_BASE 12'h000
`define EVPD_REG_SEL 12'h004
`define EVPD_REG_DATA 12'h008
`define EVPD_REG_STAT 12'h00c
`define EVPD_BASE_LSB 9
`endif

// ---- rtl/evpd_decoder.v ----
// Purpose: exception vector priority decoder and wake-up qualifier
// Assumes: one 200 MHz clock, synchronous active-high reset, apb registers
// Notes: vector answer one cycle after the core's request pulse
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`include "evpd_consts.vh"

module evpd_decoder (
   // clock and reset
   input wire clk_sys,
   input wire rst,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // exception requests
   input wire reset_cause_req,
   input wire page1_fault_req,
   input wire page2_fault_req,
   input wire soft_interrupt_instr,
   input wire kernel_call_instr,
   input wire machine_exc_req,
   input wire pin_nonmaskable_request,
   input wire ext_pin_request,
   input wire [127:0] maskable_req,
   // core state from the condition code word
   input wire imask_bit,
   input wire xmask_bit,
   input wire [2:0] current_service_level,
   input wire stop_or_wait,
   // vector interface
   input wire vec_req,
   output reg [23:0] vec_addr_q,
   output reg vec_valid_q,
   output reg [2:0] new_service_level_q,
   output reg service_level_load_q,
   // wake-up
   output reg wake_q
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // channels that own a configuration slot
   function chan_used;
      input [6:0] idx;
      begin
         chan_used = ((idx >= `EVPD_CH_MLO) && (idx <= `EVPD_CH_MHI)) ||
            (idx == `EVPD_CH_EPIN);
      end
   endfunction

   // maskable qualification, shared by vectoring and wake-up
   function qual;
      input [2:0] lvl;
      input [2:0] svc_lvl;
      input imask;
      begin
         qual = (lvl != `EVPD_LVL_OFF) && (lvl > svc_lvl) && !imask;
      end
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg [2:0] prio_q [0:127];
   reg [23:0] base_q;
   reg [6:0] sel_q;
   reg [6:0] last_idx_q;
   reg [2:0] last_lvl_q;
   integer i;
   integer k;

   // ----------------------------------------
   // maskable search
   // ----------------------------------------
   reg found_m;
   reg [6:0] best_idx;
   reg [2:0] best_lvl;
   reg epin_ok;
   reg wake_m;

   always @* begin
      found_m = 1'b0;
      best_idx = `EVPD_CH_MLO;
      best_lvl = `EVPD_LVL_OFF;
      wake_m = 1'b0;
      epin_ok = ext_pin_request &&
         qual(prio_q[`EVPD_CH_EPIN], current_service_level, imask_bit);
      // ascending scan with >= so equal levels go to the higher address
      for (i = `EVPD_CH_MLO; i <= `EVPD_CH_MHI; i = i + 1) begin
         if (maskable_req[i] && qual(prio_q[i], current_service_level, imask_bit)) begin
            wake_m = 1'b1;
            if (!found_m || (prio_q[i] >= best_lvl)) begin
               found_m = 1'b1;
               best_idx = i[6:0];
               best_lvl = prio_q[i];
            end
         end
      end
   end

   // ----------------------------------------
   // vector selection
   // ----------------------------------------
   reg [23:0] sel_ofs;
   reg [23:0] sel_vec;
   reg sel_load;
   reg [2:0] sel_lvl;

   always @* begin
      sel_load = 1'b0;
      sel_lvl = current_service_level;
      sel_ofs = `EVPD_OFS_SPUR;
      // instruction faults cannot coincide, so their order is arbitrary
      if (page1_fault_req) begin
         sel_ofs = `EVPD_OFS_PAGE1;
      end else if (page2_fault_req) begin
         sel_ofs = `EVPD_OFS_PAGE2;
      end else if (soft_interrupt_instr) begin
         sel_ofs = `EVPD_OFS_SOFT;
      end else if (kernel_call_instr) begin
         sel_ofs = `EVPD_OFS_KCALL;
      end else if (machine_exc_req) begin
         sel_ofs = `EVPD_OFS_MEXC;
      end else if (pin_nonmaskable_request && !xmask_bit) begin
         sel_ofs = `EVPD_OFS_XPIN;
      end else if (epin_ok) begin
         sel_ofs = `EVPD_OFS_EPIN;
         sel_load = 1'b1;
         sel_lvl = prio_q[`EVPD_CH_EPIN];
      end else if (found_m) begin
         sel_ofs = {15'h0000, best_idx, 2'b00};
         sel_load = 1'b1;
         sel_lvl = best_lvl;
      end
      sel_vec = base_q + sel_ofs;
      if (reset_cause_req) begin
         sel_vec = `EVPD_RESET_VEC;
         sel_load = 1'b0;
      end
   end

   // ----------------------------------------
   // vector answer
   // ----------------------------------------
   always @(posedge clk_sys) begin
      if (rst) begin
         vec_addr_q <= 24'h000000;
         vec_valid_q <= 1'b0;
         new_service_level_q <= 3'h0;
         service_level_load_q <= 1'b0;
         last_idx_q <= 7'h00;
         last_lvl_q <= 3'h0;
      end else begin
         // judged at the request itself, not at recognition
         vec_valid_q <= vec_req;
         service_level_load_q <= vec_req && sel_load;
         if (vec_req) begin
            vec_addr_q <= sel_vec;
            new_service_level_q <= sel_lvl;
            last_idx_q <= sel_ofs[8:2];
            last_lvl_q <= sel_lvl;
         end
      end
   end

   // ----------------------------------------
   // wake-up
   // ----------------------------------------
   always @(posedge clk_sys) begin
      if (rst) begin
         wake_q <= 1'b0;
      end else begin
         // the pin wakes even when masked; the core skips its handler then
         wake_q <= stop_or_wait && (wake_m || epin_ok || machine_exc_req ||
            pin_nonmaskable_request);
      end
   end

   // ----------------------------------------
   // apb register file
   // ----------------------------------------
   wire setup = psel && !penable;
   wire acc_wr = psel && penable && pready && pwrite;
   wire mapped = (paddr == `EVPD_REG_BASE) || (paddr == `EVPD_REG_SEL) ||
      (paddr == `EVPD_REG_DATA) || (paddr == `EVPD_REG_STAT);
   reg [31:0] rd_mux;

   always @* begin
      case (paddr)
         `EVPD_REG_BASE: rd_mux = {8'h00, base_q};
         `EVPD_REG_SEL: rd_mux = {25'h0000000, sel_q};
         `EVPD_REG_DATA: begin
            if (sel_q == `EVPD_CH_SPUR) begin
               rd_mux = {29'h00000000, `EVPD_LVL_SPUR};
            end else if (chan_used(sel_q)) begin
               rd_mux = {29'h00000000, prio_q[sel_q]};
            end else begin
               rd_mux = 32'h00000000;
            end
         end
         `EVPD_REG_STAT: rd_mux = {19'h00000, wake_q, last_lvl_q, 2'b00, last_idx_q};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // one wait-free access phase: ready is raised by the setup cycle
   always @(posedge clk_sys) begin
      if (rst) begin
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         if (setup) begin
            prdata <= pwrite ? 32'h00000000 : rd_mux;
            pslverr <= !mapped;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         base_q <= `EVPD_BASE_RST;
         sel_q <= 7'h00;
         for (k = 0; k < 128; k = k + 1) begin
            prio_q[k] <= `EVPD_LVL_RST;
         end
      end else if (acc_wr) begin
         // low bits fixed so the table stays aligned
         if (paddr == `EVPD_REG_BASE) begin
            base_q <= {pwdata[23:`EVPD_BASE_LSB], 9'h000};
         end
         if (paddr == `EVPD_REG_SEL) begin
            sel_q <= pwdata[6:0];
         end
         // unused and fixed channels ignore writes
         if ((paddr == `EVPD_REG_DATA) && chan_used(sel_q)) begin
            prio_q[sel_q] <= pwdata[2:0];
         end
      end
   end

endmodule

// ---- tb/evpd_decoder_asserts.sv ----
// Purpose: port checks of vector answers and wake-up
// Assumes: one clock, sync active-high reset
// Notes: fixed offsets are seen in the low nine bits, the base is writable
`timescale 1ns/10ps
module evpd_decoder_asserts (
   // clock and reset
   input wire clk_sys,
   input wire rst,
   // vector side
   input wire vec_req,
   input wire vec_valid_q,
   input wire [23:0] vec_addr_q,
   input wire service_level_load_q,
   input wire [2:0] new_service_level_q,
   // requests and core state
   input wire reset_cause_req,
   input wire machine_exc_req,
   input wire pin_nonmaskable_request,
   input wire xmask_bit,
   input wire imask_bit,
   input wire [2:0] current_service_level,
   input wire stop_or_wait,
   input wire wake_q
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence ask_s;
      vec_req ##1 vec_valid_q;
   endsequence
   sequence top_s;
      vec_req && !reset_cause_req;
   endsequence
   answer_time_a: assert property (vec_req |-> ask_s)
      else $error("no vector answer");
   no_early_a: assert property (vec_valid_q |-> $past(vec_req))
      else $error("early vector");
   addr_hold_a: assert property (!vec_req |=> $stable(vec_addr_q))
      else $error("addr moved");
   reset_vec_a: assert property (vec_req && reset_cause_req
      |=> vec_addr_q == 24'h0ffffc) else $error("reset vector wrong");
   mexc_rank_a: assert property (top_s and machine_exc_req
      |=> vec_addr_q[8:0] >= 9'h1e8) else $error("machine exception lost");
   nmi_rank_a: assert property (top_s and pin_nonmaskable_request && !xmask_bit
      |=> vec_addr_q[8:0] >= 9'h1d8 && vec_addr_q[8:0] != 9'h1dc) else $error("pin lost");
   load_qual_a: assert property (service_level_load_q |-> !$past(imask_bit)
      && new_service_level_q > $past(current_service_level)) else $error("bad load");
   wake_mask_a: assert property (stop_or_wait && imask_bit && !machine_exc_req
      && !pin_nonmaskable_request |=> !wake_q) else $error("masked wake");
   wake_pin_a: assert property (stop_or_wait && pin_nonmaskable_request |=> wake_q)
      else $error("pin did not wake");
endmodule

// ---- tb/evpd_core_model.sv ----
// Purpose: core side model, asks for vectors and tracks the service level
// Assumes: one vec_req pulse per ask pulse of the bench
// Notes: no return from handler, the bench resets to unwind nesting
`timescale 1ns/10ps
module evpd_core_model (
   // clock and reset
   input wire clk_sys,
   input wire rst,
   // bench control
   input wire ask,
   // decoder side
   input wire service_level_load_q,
   input wire [2:0] new_service_level_q,
   output logic vec_req,
   output logic [2:0] current_service_level
);
   always @(posedge clk_sys) begin
      if (rst) begin
         vec_req <= 1'h0;
         current_service_level <= 3'h0;
      end else begin
         vec_req <= ask;
         if (service_level_load_q) begin
            current_service_level <= new_service_level_q;
         end
      end
   end
endmodule

// ---- tb/tb_evpd_decoder.sv ----
// Purpose: self-checking bench of the exception vector decoder
// Assumes: default base, core model asks for vectors
// Notes: fixed requests travel as one seven-bit vector, reset cause on top
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_evpd_decoder;
   logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, ask = 0, serr;
   logic reset_cause_req = 0, page1_fault_req = 0, page2_fault_req = 0;
   logic soft_interrupt_instr = 0, kernel_call_instr = 0, machine_exc_req = 0;
   logic pin_nonmaskable_request = 0, ext_pin_request = 0, imask_bit = 1, xmask_bit = 1;
   logic stop_or_wait = 0, pready, pslverr, vec_req, vec_valid_q, service_level_load_q, wake_q;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [127:0] maskable_req = '0;
   logic [23:0] vec_addr_q;
   logic [2:0] new_service_level_q, current_service_level;
   logic [23:0] fv [7] = '{24'hffffd8, 24'hffffe8, 24'hffffec, 24'hfffff0, 24'hfffff4,
      24'hfffff8, 24'h0ffffc};
   int ch [4] = '{10, 20, 30, 40};
   int lv [4] = '{3, 3, 5, 0};
   int err_total = 0, n_tests = 0, cyc = 0;
   always #2.5 clk_sys = ~clk_sys;
   evpd_decoder i_dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .reset_cause_req, .page1_fault_req, .page2_fault_req,
      .soft_interrupt_instr, .kernel_call_instr, .machine_exc_req, .pin_nonmaskable_request,
      .ext_pin_request, .maskable_req, .imask_bit, .xmask_bit, .current_service_level,
      .stop_or_wait, .vec_req, .vec_addr_q, .vec_valid_q, .new_service_level_q,
      .service_level_load_q, .wake_q);
   evpd_core_model i_core (.clk_sys, .rst, .ask, .service_level_load_q,
      .new_service_level_q, .vec_req, .current_service_level);
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task end_of_test;
      $display("compares %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // a hang costs a mismatch, the run needs under 150 cycles
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         end_of_test();
      end
   end
   task rs;
      rst <= 1;
      repeat (6) @(posedge clk_sys);
      rst <= 0;
   endtask
   // one edge first, so a release is never overwritten in its own time step
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys) penable <= 1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      serr = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task vec(input logic [23:0] ea, input logic [2:0] el, input logic ld);
      @(posedge clk_sys) ask <= 1;
      @(posedge clk_sys) ask <= 0;
      repeat (3) begin
         @(posedge clk_sys);
         if (vec_valid_q === 1'b1) break;
      end
      `CHK("vector", ea, vec_addr_q)
      `CHK("load", ld, service_level_load_q)
      if (ld) `CHK("level", el, new_service_level_q)
   endtask
   task wk(input logic e);
      repeat (2) @(posedge clk_sys);
      `CHK("wake", e, wake_q)
   endtask
   task fix(input logic [6:0] f);
      {reset_cause_req, page1_fault_req, page2_fault_req, soft_interrupt_instr,
         kernel_call_instr, machine_exc_req, pin_nonmaskable_request} <= f;
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      rs();
      apb(0, 12'h000, '0);
      `CHK("base", 32'h00fffe00, rd)
      apb(1, 12'h004, 32'h04);
      apb(0, 12'h008, '0);
      `CHK("level4", 32'h01, rd)
      apb(1, 12'h004, 32'h77);
      apb(0, 12'h008, '0);
      `CHK("level_spur", 32'h07, rd)
      apb(0, 12'h010, '0);
      `CHK("slverr", 1'b1, serr)
      imask_bit <= 0;
      vec(24'hffffdc, 0, 0);
      apb(1, 12'h000, 32'h00aa0000);
      vec(24'haa01dc, 0, 0);
      apb(1, 12'h000, 32'h00fffe00);
      $display("test registers and spurious done");
      maskable_req[4] <= 1;
      ext_pin_request <= 1;
      vec(24'hffffd4, 1, 1);
      xmask_bit <= 0;
      for (int k = 0; k < 7; k++) begin
         fix(7'h7f >> (6 - k));
         vec(fv[k], 0, 0);
      end
      fix('0);
      ext_pin_request <= 0;
      $display("test fixed order done");
      rs();
      for (int k = 0; k < 4; k++) begin
         apb(1, 12'h004, ch[k]);
         apb(1, 12'h008, lv[k]);
      end
      imask_bit <= 0;
      maskable_req <= 128'h10000100400;
      vec(24'hfffe50, 3, 1);
      stop_or_wait <= 1;
      wk(0);
      imask_bit <= 1;
      maskable_req <= 128'h10040100400;
      wk(0);
      imask_bit <= 0;
      wk(1);
      vec(24'hfffe78, 5, 1);
      apb(0, 12'h00c, '0);
      `CHK("status", 32'h00000a1e, rd)
      vec(24'hffffdc, 0, 0);
      xmask_bit <= 1;
      fix(7'h01);
      wk(1);
      fix(7'h02);
      wk(1);
      fix('0);
      $display("test nesting and wake done");
      end_of_test();
   end
endmodule
bind evpd_decoder evpd_decoder_asserts i_chk (.clk_sys, .rst, .vec_req, .vec_valid_q,
   .vec_addr_q, .service_level_load_q, .new_service_level_q, .reset_cause_req,
   .machine_exc_req, .pin_nonmaskable_request, .xmask_bit, .imask_bit,
   .current_service_level, .stop_or_wait, .wake_q);
